/* File: logic/asr_cfg.svh */
// Purpose: shared constants of the converter readout port
// Assumes: system clock of 20 ns period
// Notes:   definitions only
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH

// result word
`define ASR_RES_BITS 18
`define ASR_MSB_IDX 17

// timing in ns and in system clock cycles
`define ASR_SYS_NS 20
`define ASR_CONV_NS 412
`define ASR_CONV_CYC (`ASR_CONV_NS / `ASR_SYS_NS)
`define ASR_ACQ_NS 200
`define ASR_ACQ_CYC ((`ASR_ACQ_NS + `ASR_SYS_NS - 1) / `ASR_SYS_NS)

// link edge counter and forwarding ring
`define ASR_CNT_W 8
`define ASR_RING_AW 5
`define ASR_RING_N 32

`endif

/* File: logic/asr_pkg.sv */
// Purpose: types of the converter readout port
// Assumes: nothing
// Notes:   one-hot state codes
`default_nettype none
package asr_pkg;
    // conversion sequencer states
    typedef enum logic [1:0] {
        ASR_IDLE = 2'b01,
        ASR_CONV = 2'b10
    } asr_conv_state_t;
endpackage
`default_nettype wire

/* File: logic/asr_sync2.sv */
// Purpose: two flip-flop synchroniser
// Assumes: input bits change independently or are gray coded
// Notes:   first stage feeds only the second
`default_nettype none
module asr_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_reg;  // first stage
    logic [W-1:0] s2_reg;  // second stage

    // register both stages
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
        end
    end

    assign q = s2_reg;
endmodule
`default_nettype wire

/* File: logic/asr_conv_ctrl.sv */
// Purpose: conversion sequencer timed by the system clock
// Assumes: start_pulse is one cycle, on clk_sys
// Notes:   result holds until the next conversion ends
`default_nettype none
`include "asr_cfg.svh"
module asr_conv_ctrl
    import asr_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // request and sampled code
    input  wire logic                       start_pulse,
    input  wire logic [`ASR_RES_BITS-1:0]   conv_code,
    // status and result
    output logic                            busy,
    output logic                            done,
    output logic      [`ASR_RES_BITS-1:0]   result
);
    localparam logic [4:0] CONV_LAST = 5'(`ASR_CONV_CYC - 1);

    asr_conv_state_t            state_reg, state_next;  // sequencer
    logic [4:0]                 cnt_reg, cnt_next;      // cycle count
    logic                       busy_reg, busy_next;    // converting
    logic                       done_reg, done_next;    // end pulse
    logic [`ASR_RES_BITS-1:0]   result_reg, result_next;

    // next state of the sequencer
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        busy_next   = busy_reg;
        done_next   = 1'b0;
        result_next = result_reg;
        case (state_reg)
            ASR_IDLE: begin
                if (start_pulse) begin
                    state_next = ASR_CONV;
                    cnt_next   = 5'h00;
                    busy_next  = 1'b1;
                end
            end
            ASR_CONV: begin
                if (cnt_reg == CONV_LAST) begin
                    state_next  = ASR_IDLE;
                    busy_next   = 1'b0;
                    done_next   = 1'b1;
                    result_next = conv_code;
                end else begin
                    cnt_next = cnt_reg + 5'h01;
                end
            end
            default: begin
                state_next = ASR_IDLE;
                busy_next  = 1'b0;
            end
        endcase
    end

    // register the sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg  <= ASR_IDLE;
            cnt_reg    <= 5'h00;
            busy_reg   <= 1'b0;
            done_reg   <= 1'b0;
            result_reg <= '0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            busy_reg   <= busy_next;
            done_reg   <= done_next;
            result_reg <= result_next;
        end
    end

    assign busy   = busy_reg;
    assign done   = done_reg;
    assign result = result_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_busy_run;
        busy_reg [*8] ##1 busy_reg [*8] ##1 busy_reg [*4];
    endsequence

    a_busy_whole_conv: assert property (
        $rose(busy_reg) |-> s_busy_run ##1 !busy_reg
    ) else $error("busy not held for the whole conversion");

    a_no_restart: assert property (
        (state_reg == ASR_CONV && cnt_reg != CONV_LAST && start_pulse)
        |=> busy_reg && cnt_reg == $past(cnt_reg) + 5'h01
    ) else $error("conversion restarted while busy");

    a_conv_time_bound: assert property (
        $rose(busy_reg) |-> ##[1:20] ($fell(busy_reg) && done_reg)
    ) else $error("conversion overran its time");

    a_result_hold: assert property (
        $changed(result_reg) |-> done_reg && $fell(busy_reg)
    ) else $error("result changed outside conversion end");
endmodule
`default_nettype wire

/* File: logic/asr_readout.sv */
// Purpose: serial readout port of an 18-bit converter
// Assumes: link_sck is the host shift clock, idles between frames
// Notes:   output shift state lives on clk_sys, edges cross in gray
`default_nettype none
`include "asr_cfg.svh"
module asr_readout
    import asr_pkg::*;
(
    // system clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // host shift clock
    input  wire logic                       link_sck,
    // host pins
    input  wire logic                       convert_start,
    input  wire logic                       read_enable_or_link_input,
    input  wire logic                       chain_mode_pin,
    // sampled code from the analog core
    input  wire logic [`ASR_RES_BITS-1:0]   conv_code,
    // serial data pin, drive enable low while driving
    output logic                            serial_data_out,
    output logic                            serial_data_oe_n,
    // status
    output logic                            busy,
    output logic                            core_powered
);
    //------------------------------------------------------------
    // link clock domain
    //------------------------------------------------------------
    // the ring is written here and read from the system side; a slot is
    // read only once it is eighteen edges old, long settled by then, and
    // is rewritten no sooner than thirty-two edges after its capture
    logic [`ASR_CNT_W-1:0]   lcnt_reg, lcnt_next;    // edge count
    logic [`ASR_CNT_W-1:0]   lgray_reg, lgray_next;  // gray copy
    logic [`ASR_RING_N-1:0]  ring_reg, ring_next;    // link bits
    logic [`ASR_RING_AW-1:0] lptr_w;                 // write slot

    assign lptr_w = lcnt_reg[`ASR_RING_AW-1:0];

    // count rising edges and capture the link input
    always_comb begin
        ring_next = ring_reg;
        ring_next[lptr_w] = read_enable_or_link_input;
        lcnt_next  = lcnt_reg + 8'h01;
        lgray_next = lcnt_next ^ (lcnt_next >> 1);
    end

    // register link domain state
    always_ff @(posedge link_sck or posedge rst) begin
        if (rst) begin
            lcnt_reg  <= 8'h00;
            lgray_reg <= 8'h00;
            ring_reg  <= 32'h0000_0000;
        end else begin
            lcnt_reg  <= lcnt_next;
            lgray_reg <= lgray_next;
            ring_reg  <= ring_next;
        end
    end

    //------------------------------------------------------------
    // crossings into the system domain
    //------------------------------------------------------------
    // every host pin meets two flops before any logic sees it, except the link
    // input, which the ring also takes in directly on link_sck; the link edge count
    // crosses as gray code so a sample taken mid-change is off by at most one edge,
    // never a wild value
    logic [2:0]              pin_raw;   // raw host pins
    logic [2:0]              pin_s;     // synchronised pins
    logic                    start_s;   // conversion start level
    logic                    ren_s;     // select / link input level
    logic                    mode_s;    // chain mode level
    logic [`ASR_CNT_W-1:0]   gray_s;    // synchronised edge count
    logic [`ASR_CNT_W-1:0]   cnt_bin;   // decoded edge count

    // the select travels inverted so that the cleared synchroniser
    // reads as deselected: the pin stays released right after reset
    assign pin_raw = {convert_start, ~read_enable_or_link_input,
                      chain_mode_pin};

    // host pins through two flops
    asr_sync2 #(.W(3)) u_pin_sync (
        .clk (clk_sys),
        .rst (rst),
        .d   (pin_raw),
        .q   (pin_s)
    );

    assign start_s = pin_s[2];
    // undo the inversion taken before the flops
    assign ren_s   = ~pin_s[1];
    assign mode_s  = pin_s[0];

    // edge count as gray code, one bit moves per edge
    asr_sync2 #(.W(`ASR_CNT_W)) u_cnt_sync (
        .clk (clk_sys),
        .rst (rst),
        .d   (lgray_reg),
        .q   (gray_s)
    );

    // the decoded count is only used as a difference, so wrap-around at
    // the top of the counter is harmless
    // gray to binary, one xor reduction per bit
    genvar gi;
    generate
        for (gi = 0; gi < `ASR_CNT_W; gi++) begin : g_gray
            assign cnt_bin[gi] = ^gray_s[`ASR_CNT_W-1:gi];
        end
    endgenerate

    //------------------------------------------------------------
    // conversion sequencer
    //------------------------------------------------------------
    logic                     start_d_reg;  // start level, delayed
    logic                     start_pulse;  // start rising edge
    logic                     busy_w;       // converting
    logic                     done_w;       // conversion end pulse
    logic [`ASR_RES_BITS-1:0] result_w;     // held result

    // start_d_reg clears to the idle level of the start pin, so no false
    // edge follows reset; edges seen while busy are dropped by the sequencer
    // rising start edge
    assign start_pulse = start_s & ~start_d_reg;

    asr_conv_ctrl u_conv (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .start_pulse (start_pulse),
        .conv_code   (conv_code),
        .busy        (busy_w),
        .done        (done_w),
        .result      (result_w)
    );

    assign busy = busy_w;

    //------------------------------------------------------------
    // output shift position and data pin
    //------------------------------------------------------------
    // the pin flops sit on the system clock, so each bit follows its
    // shift edge by the two-flop crossing plus one register, up to 60 ns,
    // just inside one 64 ns link clock period; the host must leave that much room
    logic                     ren_d_reg;          // select, delayed
    logic                     ren_fall;           // select taken low
    logic                     load_w;             // new frame origin
    logic [`ASR_CNT_W-1:0]    base_reg, base_next; // count at origin
    logic [`ASR_CNT_W-1:0]    k_w;                // bits shifted
    logic [`ASR_CNT_W-1:0]    back_w;             // count minus word
    logic [`ASR_RING_AW-1:0]  ridx_w;             // ring read slot
    logic [4:0]               own_idx;            // own bit index
    logic                     sdo_reg, sdo_next;
    logic                     oe_n_reg, oe_n_next;
    logic                     pwr_reg, pwr_next;

    assign ren_fall = ~mode_s & ~ren_s & ren_d_reg;
    assign load_w   = done_w | ren_fall;

    // shift position relative to frame origin
    always_comb begin
        base_next = load_w ? cnt_bin : base_reg;
        k_w       = cnt_bin - base_next;
        back_w    = cnt_bin - 8'(`ASR_RES_BITS);
        ridx_w    = back_w[`ASR_RING_AW-1:0];
        own_idx   = 5'(8'(`ASR_MSB_IDX) - k_w);
    end

    // next value of the data pin and its enable
    always_comb begin
        if (k_w < 8'(`ASR_RES_BITS)) begin
            sdo_next = result_w[own_idx];
        end else if (mode_s) begin
            sdo_next = ring_reg[ridx_w];
        end else begin
            // normal mode pads with zeros
            sdo_next = 1'b0;
        end
        // sharing relies on one select low
        oe_n_next = ~mode_s & ren_s;
        pwr_next  = busy_w;
    end

    // register system domain state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            start_d_reg <= 1'b0;
            ren_d_reg   <= 1'b1;
            base_reg    <= 8'h00;
            sdo_reg     <= 1'b0;
            oe_n_reg    <= 1'b1;
            pwr_reg     <= 1'b0;
        end else begin
            start_d_reg <= start_s;
            ren_d_reg   <= ren_s;
            base_reg    <= base_next;
            sdo_reg     <= sdo_next;
            oe_n_reg    <= oe_n_next;
            pwr_reg     <= pwr_next;
        end
    end

    assign serial_data_out  = sdo_reg;
    assign serial_data_oe_n = oe_n_reg;
    assign core_powered     = pwr_reg;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    // a frame origin that has not yet seen a shift edge
    sequence s_origin_wait;
        !load_w && k_w == 8'h00;
    endsequence

    // the first shift edge of a frame reaches the system side
    sequence s_first_shift;
        s_origin_wait ##1 (!load_w && k_w == 8'h01);
    endsequence

    a_normal_release: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!mode_s && ren_s) |=> oe_n_reg
    ) else $error("pin driven while deselected");

    a_normal_drive: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!mode_s && !ren_s) |=> !oe_n_reg
    ) else $error("pin released while selected");

    a_msb_at_done: assert property (
        @(posedge clk_sys) disable iff (rst)
        $fell(busy_w) |=> sdo_reg == result_w[`ASR_MSB_IDX]
    ) else $error("top bit missing after busy fell");

    a_msb_on_select: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ren_fall && !done_w)
        |=> sdo_reg == result_w[`ASR_MSB_IDX] && !oe_n_reg
    ) else $error("top bit missing after select");

    a_chain_drive: assert property (
        @(posedge clk_sys) disable iff (rst)
        mode_s |=> !oe_n_reg
    ) else $error("pin released in chain mode");

    a_chain_forward: assert property (
        @(posedge clk_sys) disable iff (rst)
        (mode_s && !load_w && k_w == 8'h12)
        |=> sdo_reg == ring_reg[$past(ridx_w)]
    ) else $error("upstream top bit not forwarded");

    a_link_capture: assert property (
        @(posedge link_sck) disable iff (rst)
        1'b1 |=> ring_reg[$past(lptr_w)] == $past(read_enable_or_link_input)
    ) else $error("link input not captured on edge");

    a_shift_edge: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!load_w && !$past(load_w) && $stable(k_w) && $stable(pin_s))
        |=> $stable(sdo_reg)
    ) else $error("data changed without a shift edge");

    a_own_second_bit: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_first_shift |=> sdo_reg == $past(result_w[`ASR_MSB_IDX-1])
    ) else $error("second bit not next to top bit");

    a_power_track: assert property (
        @(posedge clk_sys) disable iff (rst)
        core_powered == $past(busy_w)
    ) else $error("power flag does not follow busy");

    a_normal_pad: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!mode_s && !load_w && k_w >= 8'(`ASR_RES_BITS)) |=> !sdo_reg
    ) else $error("normal mode bit beyond the word not zero");

    a_gray_step: assert property (
        @(posedge clk_sys) disable iff (rst)
        $onehot0(gray_s ^ $past(gray_s))
    ) else $error("edge count moved by more than one step");
endmodule
`default_nettype wire

/* File: verif/asr_host_model.sv */
// Purpose: host controller model driving the shift clock and link input
// Assumes: link clock period 64 ns, standing low between frames
// Notes:   each bit is captured just before the next rising shift edge
`default_nettype none
module asr_host_model (
    // frame request from the bench
    input  wire logic        frame_go,
    input  wire logic [6:0]  frame_len,
    input  wire logic [63:0] link_bits,
    output logic             frame_done,
    // link pins
    output logic             link_sck,
    output logic             link_data,
    input  wire logic        sdo_pin,
    // captured bits, last one in the lsb
    output logic      [63:0] cap_word
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial begin
        link_sck   = 1'b0;
        link_data  = 1'b0;
        frame_done = 1'b0;
        cap_word   = '0;
    end

    // one frame per request; odd start offset keeps phase unrelated
    always @(posedge frame_go) begin
        #7;
        cap_word  = '0;
        // upstream bit ready before first rise
        link_data = link_bits[frame_len-1];
        for (int i = 0; i < frame_len; i++) begin
            #32;
            cap_word = {cap_word[62:0], sdo_pin};
            link_sck = 1'b1;
            #2;
            // next link bit only after the rising edge
            if (i + 1 < frame_len) begin
                link_data = link_bits[frame_len-2-i];
            end
            #30;
            link_sck = 1'b0;
        end
        // released line shows the inverse of its last value
        link_data  = ~link_data;
        frame_done = 1'b1;
        wait (frame_go == 1'b0);
        frame_done = 1'b0;
    end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: self-checking bench of the converter readout port
// Assumes: host model supplies shift clock and chain input
// Notes:   outputs are observed on the falling system clock edge
`default_nettype none
`include "asr_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk_sys, rst, convert_start, chain_mode_pin, sel_n;
    logic [17:0] conv_code;      // code from the analog core
    logic        frame_go;       // frame request to the host
    logic [6:0]  frame_len;
    logic [63:0] link_bits;
    wire         link_sck, link_data, rd_in, sdo, oe_n, busy, core_powered;
    wire         sdo_pin, frame_done;
    wire  [63:0] cap_word;
    int          mismatches, n_compared;

    // pin level seen by the host; no pull on the shared line
    assign sdo_pin = oe_n ? 1'bz : sdo;
    // select in normal mode, link data in chain mode
    assign rd_in   = chain_mode_pin ? link_data : sel_n;

    asr_readout dut (
        .clk_sys(clk_sys), .rst(rst), .link_sck(link_sck),
        .convert_start(convert_start), .read_enable_or_link_input(rd_in),
        .chain_mode_pin(chain_mode_pin), .conv_code(conv_code),
        .serial_data_out(sdo), .serial_data_oe_n(oe_n),
        .busy(busy), .core_powered(core_powered)
    );
    asr_host_model host (
        .frame_go(frame_go), .frame_len(frame_len), .link_bits(link_bits),
        .frame_done(frame_done), .link_sck(link_sck), .link_data(link_data),
        .sdo_pin(sdo_pin), .cap_word(cap_word)
    );

    // system clock, 20 ns period
    always #10 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------
    task automatic check_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_word(input string name, input logic [63:0] exp,
                              input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // shared drivers
    // ------------------------------------------------------------
    // start a conversion, time busy, then look at the pin and power
    task automatic do_conv(input logic [17:0] code, input bit retrig,
                           input logic pin_exp);
        int n;
        int cnt;
        n = 0;
        cnt = 0;
        @(posedge clk_sys);
        conv_code     <= code;
        convert_start <= 1'b1;
        do begin
            @(negedge clk_sys);
            n++;
        end while (busy !== 1'b1 && n < 10);
        while (busy === 1'b1 && cnt < 40) begin
            cnt++;
            @(posedge clk_sys);
            // a second start edge in mid-conversion must be ignored
            if (cnt == 1 || (retrig && cnt == 10)) convert_start <= 1'b0;
            if (retrig && cnt == 6) convert_start <= 1'b1;
            @(negedge clk_sys);
        end
        check_word("busy_cycles", 64'(`ASR_CONV_CYC), 64'(cnt));
        @(negedge clk_sys);
        check_bit("pin_after_busy", pin_exp, sdo_pin);
        check_bit("core_powered", 1'b0, core_powered);
        n = 0;
        repeat (8) begin
            @(negedge clk_sys);
            if (busy !== 1'b0) n++;
        end
        check_word("busy_restart", 64'h0, 64'(n));
    endtask

    // ask the host for one frame and wait for it under a bound
    task automatic run_frame(input logic [6:0] len, input logic [63:0] bits);
        int n;
        n = 0;
        @(posedge clk_sys);
        frame_len <= len;
        link_bits <= bits;
        frame_go  <= 1'b1;
        while (frame_done !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        check_bit("frame_done", 1'b1, frame_done);
        @(posedge clk_sys);
        frame_go <= 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        @(negedge clk_sys);
        check_bit("busy_reset", 1'b0, busy);
        check_bit("powered_reset", 1'b0, core_powered);
        check_bit("oe_n_reset", 1'b1, oe_n);
    endtask

    // deselected device converts, restart ignored, pin stays released
    task automatic t_retrig;
        do_conv(18'h3ffff, 1'b1, 1'bz);
    endtask

    // select held low: top bit at busy fall, then the whole word
    task automatic t_single;
        @(posedge clk_sys) sel_n <= 1'b0;
        do_conv(18'h2a5c3, 1'b0, 1'b1);
        run_frame(7'd18, 64'h0);
        check_word("single_word", {46'h0, 18'h2a5c3}, cap_word);
        @(posedge clk_sys) sel_n <= 1'b1;
        repeat (5) @(negedge clk_sys);
    endtask

    // shared line: select idles high, pulled low singly to read
    task automatic t_shared;
        do_conv(18'h15a5a, 1'b0, 1'bz);
        @(posedge clk_sys) sel_n <= 1'b0;
        repeat (4) @(negedge clk_sys);
        check_bit("select_top_bit", 1'b0, sdo_pin);
        run_frame(7'd18, 64'h0);
        check_word("shared_word", {46'h0, 18'h15a5a}, cap_word);
        @(posedge clk_sys) sel_n <= 1'b1;
        repeat (5) @(negedge clk_sys);
        check_bit("release_pin", 1'bz, sdo_pin);
    endtask

    // chain: own word, then upstream word forwarded msb first
    task automatic t_chain;
        @(posedge clk_sys) chain_mode_pin <= 1'b1;
        repeat (5) @(negedge clk_sys);
        check_bit("chain_oe_n", 1'b0, oe_n);
        do_conv(18'h1b2e4, 1'b0, 1'b0);
        run_frame(7'd36, {28'h0, 18'h2c3a9, 18'h0f0f0});
        check_word("chain_word", {28'h0, 18'h1b2e4, 18'h2c3a9},
                   cap_word);
        check_bit("chain_oe_n_end", 1'b0, oe_n);
        @(posedge clk_sys) chain_mode_pin <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        convert_start = 1'b0;
        chain_mode_pin = 1'b0;
        sel_n = 1'b1;
        conv_code = 18'h0;
        frame_go = 1'b0;
        frame_len = 7'h0;
        link_bits = 64'h0;
        mismatches = 0;
        n_compared = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) begin
            @(negedge clk_sys);
            check_bit("oe_n_release", 1'b1, oe_n);
        end
        t_reset();
        t_retrig();
        t_single();
        t_shared();
        t_chain();
        end_sim();
    end

    // about 8 us of tests; far longer means a hang
    initial begin
        #100000;
        mismatches++;
        $display("ERROR watchdog expected finish seen timeout");
        end_sim();
    end
endmodule
`default_nettype wire
